// *** rtl/atou_cfg.svh ***
// Notes on behaviour
// R1 - trigger level bit picks output low or high
// R2 - trigger level applied only if update enabled
// R3 - each pin: digital input, open-drain or push-pull
// R4 - digital input levels readable in readback register
// R5 - open-drain: released when high, pulls low otherwise
// R6 - push-pull: always drives, one side on
// R7 - enable bit one: alerts update output
// R8 - per-output select picks alerting channels
// R9 - simultaneous triggers all load on next edge
`ifndef ATOU_CFG_SVH
`define ATOU_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ATOU_OFF_PIN_DIGITAL 12'h000
`define ATOU_OFF_PIN_OUTPUT 12'h004
`define ATOU_OFF_PIN_PUSH_PULL 12'h008
`define ATOU_OFF_OUTPUT_LEVEL 12'h00c
`define ATOU_OFF_INPUT_READBACK 12'h010
`define ATOU_OFF_TRIG_ENABLE 12'h014
`define ATOU_OFF_TRIG_LEVEL 12'h018
`define ATOU_OFF_IRQ_STATUS 12'h01c
`define ATOU_OFF_IRQ_MASK 12'h020
`define ATOU_OFF_SEL_BASE 12'h040
`define ATOU_SEL_STRIDE 12'h004

// ----------------------------------------
// reset values
// ----------------------------------------
`define ATOU_RST_ZERO 8'h00
`define ATOU_RST_SEL 8'h02

// ----------------------------------------
// widths and limits
// ----------------------------------------
`define ATOU_DATA_W 32
`define ATOU_MAX_CH 8

`endif

// *** rtl/atou_pkg.sv ***
package atou_pkg;

    // per-pin function decoded from the three configuration bits
    typedef enum logic [1:0] {
        ATOU_PIN_ANALOG = 2'b00,
        ATOU_PIN_DIG_IN = 2'b01,
        ATOU_PIN_OPEN_DRAIN = 2'b10,
        ATOU_PIN_PUSH_PULL = 2'b11
    } atou_pin_mode_t;

    // bus answer state
    typedef enum logic [0:0] {
        ATOU_BUS_WAIT = 1'b0,
        ATOU_BUS_REPLY = 1'b1
    } atou_bus_state_t;

endpackage

// *** rtl/atou_sync.sv ***
`timescale 1ns/1ps
module atou_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule

// *** rtl/atou_top.sv ***
`timescale 1ns/1ps
`include "atou_cfg.svh"
module atou_top #(
    parameter int CH = 8,
    parameter int AW = 12
) (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RESET_N_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // alert flags from the converter, same clock
    input wire logic [CH-1:0] ALERT_FLAGS_IN,
    // channel pins
    input wire logic [CH-1:0] CHANNEL_PIN_IN,
    output logic [CH-1:0] CHANNEL_PIN_OUT,
    output logic [CH-1:0] CHANNEL_PIN_OE_OUT,
    // interrupt
    output logic IRQ_OUT
);
    import atou_pkg::*;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (CH < 1 || CH > `ATOU_MAX_CH) begin : g_bad_ch
        $error("CH must lie between 1 and 8");
    end
    if (AW < 8 || AW > 12) begin : g_bad_aw
        $error("AW must lie between 8 and 12");
    end

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    // address of the alert source select register of one output
    function automatic logic sel_hit(input logic [AW-1:0] addr, input int idx);
        logic [11:0] off;
        off = `ATOU_OFF_SEL_BASE + 12'(idx) * `ATOU_SEL_STRIDE;
        return 12'(addr) == off;
    endfunction

    // fixed register address match
    function automatic logic reg_hit(input logic [AW-1:0] addr, input logic [11:0] off);
        return 12'(addr) == off;
    endfunction

    // pin function from configuration bits [R3]
    function automatic atou_pin_mode_t pin_mode(input logic dig, input logic outp, input logic pp);
        atou_pin_mode_t m;
        m = ATOU_PIN_ANALOG;
        if (dig && !outp) begin
            m = ATOU_PIN_DIG_IN;
        end else if (dig && outp && !pp) begin
            m = ATOU_PIN_OPEN_DRAIN;
        end else if (dig && outp && pp) begin
            m = ATOU_PIN_PUSH_PULL;
        end
        return m;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [CH-1:0] pin_digital;
    logic [CH-1:0] pin_output;
    logic [CH-1:0] pin_push_pull;
    logic [CH-1:0] output_level;
    logic [CH-1:0] input_level_readback;
    logic [CH-1:0] trigger_update_enable;
    logic [CH-1:0] trigger_output_level;
    logic [CH-1:0] irq_status;
    logic [CH-1:0] irq_mask;
    logic [CH-1:0] alert_source_select [CH];
    logic [CH-1:0] source_prev;
    logic [CH-1:0] pin_sync;
    atou_bus_state_t bus_state;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire access = PSEL_IN & PENABLE_IN & (bus_state == ATOU_BUS_WAIT);
    wire wr = access & PWRITE_IN & PSTRB_IN[0];
    wire rd = access & ~PWRITE_IN;
    wire [CH-1:0] wdata = PWDATA_IN[CH-1:0];
    wire hit_dig = reg_hit(PADDR_IN, `ATOU_OFF_PIN_DIGITAL);
    wire hit_out = reg_hit(PADDR_IN, `ATOU_OFF_PIN_OUTPUT);
    wire hit_pp = reg_hit(PADDR_IN, `ATOU_OFF_PIN_PUSH_PULL);
    wire hit_lvl = reg_hit(PADDR_IN, `ATOU_OFF_OUTPUT_LEVEL);
    wire hit_rb = reg_hit(PADDR_IN, `ATOU_OFF_INPUT_READBACK);
    wire hit_en = reg_hit(PADDR_IN, `ATOU_OFF_TRIG_ENABLE);
    wire hit_tl = reg_hit(PADDR_IN, `ATOU_OFF_TRIG_LEVEL);
    wire hit_st = reg_hit(PADDR_IN, `ATOU_OFF_IRQ_STATUS);
    wire hit_mk = reg_hit(PADDR_IN, `ATOU_OFF_IRQ_MASK);
    logic [CH-1:0] hit_sel;
    logic [CH-1:0] sel_rdata;

    // select register read mux
    always_comb begin
        hit_sel = '0;
        sel_rdata = '0;
        for (int i = 0; i < CH; i++) begin
            hit_sel[i] = sel_hit(PADDR_IN, i);
            sel_rdata = sel_rdata | (hit_sel[i] ? alert_source_select[i] : '0);
        end
    end

    wire mapped = hit_dig | hit_out | hit_pp | hit_lvl | hit_rb | hit_en | hit_tl | hit_st | hit_mk | (|hit_sel);
    wire [CH-1:0] reg_rdata = ({CH{hit_dig}} & pin_digital) | ({CH{hit_out}} & pin_output)
        | ({CH{hit_pp}} & pin_push_pull) | ({CH{hit_lvl}} & output_level)
        | ({CH{hit_rb}} & input_level_readback) | ({CH{hit_en}} & trigger_update_enable)
        | ({CH{hit_tl}} & trigger_output_level) | ({CH{hit_st}} & irq_status)
        | ({CH{hit_mk}} & irq_mask) | sel_rdata;
    wire [31:0] next_prdata = (rd && mapped) ? {{(32-CH){1'b0}}, reg_rdata} : 32'h0000_0000;

    // ----------------------------------------
    // trigger logic, one lane per output
    // ----------------------------------------
    logic [CH-1:0] source_any;
    logic [CH-1:0] fire;
    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : g_lane
            // any selected channel flag counts as this output's source [R8]
            assign source_any[g] = |(ALERT_FLAGS_IN & alert_source_select[g]);
            // fire on the rising edge of the source, only while enabled [R2] [R7]
            assign fire[g] = source_any[g] & ~source_prev[g] & trigger_update_enable[g];
        end
    endgenerate

    // all firing lanes load in the same edge; trigger beats a same-cycle software write [R9] [R1]
    wire [CH-1:0] sw_level = (wr && hit_lvl) ? wdata : output_level;
    wire [CH-1:0] next_output_level = (sw_level & ~fire) | (trigger_output_level & fire);

    // read of status clears, a new event in that cycle still sets
    wire [CH-1:0] next_irq_status = (irq_status & ~{CH{rd && hit_st}}) | fire;
    wire next_irq = |(next_irq_status & irq_mask);

    // ----------------------------------------
    // pin drive and readback
    // ----------------------------------------
    logic [CH-1:0] next_pin_out;
    logic [CH-1:0] next_pin_oe;
    logic [CH-1:0] next_readback;

    // per-pin driver; pins follow the level register one edge later
    always_comb begin
        next_pin_out = '0;
        next_pin_oe = '0;
        next_readback = '0;
        for (int i = 0; i < CH; i++) begin
            case (pin_mode(pin_digital[i], pin_output[i], pin_push_pull[i]))
                ATOU_PIN_DIG_IN: begin
                    next_readback[i] = pin_sync[i]; // [R4]
                end
                ATOU_PIN_OPEN_DRAIN: begin
                    next_pin_oe[i] = ~output_level[i]; // low only; released high [R5]
                end
                ATOU_PIN_PUSH_PULL: begin
                    next_pin_out[i] = output_level[i]; // always driven [R6]
                    next_pin_oe[i] = 1'b1;
                end
                default: begin
                    next_pin_oe[i] = 1'b0;
                end
            endcase
        end
    end

    // pins come from outside the clock domain
    atou_sync #(
        .W(CH)
    ) u_pin_sync (
        .clk_in(MCLK_IN),
        .rst_n_in(RESET_N_IN),
        .d_in(CHANNEL_PIN_IN),
        .q_out(pin_sync)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // bus answer: one wait state, so ready is never stuck high across transfers
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            bus_state <= ATOU_BUS_WAIT;
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
        end else begin
            bus_state <= access ? ATOU_BUS_REPLY : ATOU_BUS_WAIT;
            PREADY_OUT <= access;
            PSLVERR_OUT <= access & ~mapped;
            PRDATA_OUT <= next_prdata;
        end
    end

    // configuration written by software
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            pin_digital <= CH'(`ATOU_RST_ZERO);
            pin_output <= CH'(`ATOU_RST_ZERO);
            pin_push_pull <= CH'(`ATOU_RST_ZERO);
            trigger_update_enable <= CH'(`ATOU_RST_ZERO);
            trigger_output_level <= CH'(`ATOU_RST_ZERO);
            irq_mask <= CH'(`ATOU_RST_ZERO);
        end else if (wr) begin
            if (hit_dig) pin_digital <= wdata; // [R3]
            if (hit_out) pin_output <= wdata; // [R3]
            if (hit_pp) pin_push_pull <= wdata; // [R3]
            if (hit_en) trigger_update_enable <= wdata; // [R7]
            if (hit_tl) trigger_output_level <= wdata; // [R1]
            if (hit_mk) irq_mask <= wdata;
        end
    end

    // alert source selects, one register per output
    generate
        for (g = 0; g < CH; g++) begin : g_sel
            always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    alert_source_select[g] <= CH'(`ATOU_RST_SEL);
                end else if (wr && hit_sel[g]) begin
                    alert_source_select[g] <= wdata; // [R8]
                end
            end
        end
    endgenerate

    // block state and outputs
    always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            output_level <= CH'(`ATOU_RST_ZERO);
            source_prev <= '0;
            irq_status <= '0;
            IRQ_OUT <= 1'b0;
            input_level_readback <= '0;
            CHANNEL_PIN_OUT <= '0;
            CHANNEL_PIN_OE_OUT <= '0;
        end else begin
            output_level <= next_output_level; // [R1] [R9]
            source_prev <= source_any;
            irq_status <= next_irq_status;
            IRQ_OUT <= next_irq;
            input_level_readback <= next_readback; // [R4]
            CHANNEL_PIN_OUT <= next_pin_out; // [R6]
            CHANNEL_PIN_OE_OUT <= next_pin_oe; // [R5]
        end
    end
endmodule

// *** test/atou_pins_model.sv ***
`timescale 1ns/1ps
// ----
// board side of the channel pins
// ----
module atou_pins_model #(
    parameter int CH = 8
) (
    // drive from the block
    input wire logic [CH-1:0] drive_in,
    input wire logic [CH-1:0] oe_in,
    // external source, only where it is switched in
    input wire logic [CH-1:0] src_in,
    input wire logic [CH-1:0] src_en_in,
    // resolved line level
    output logic [CH-1:0] pin_out
);
    // an undriven line floats up through the board pull-up
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            pin_out[i] = oe_in[i] ? drive_in[i] : (src_en_in[i] ? src_in[i] : 1'b1);
        end
    end
endmodule

// *** test/atou_top_chk.sv ***
`timescale 1ns/1ps
// ----
// port watcher
// ----
module atou_top_chk #(
    parameter int CH = 8,
    parameter int AW = 12
) (
    input wire logic MCLK_IN, RESET_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN,
    input wire logic [AW-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN, PRDATA_OUT,
    input wire logic [3:0] PSTRB_IN,
    input wire logic PREADY_OUT, PSLVERR_OUT, IRQ_OUT,
    input wire logic [CH-1:0] ALERT_FLAGS_IN, CHANNEL_PIN_IN, CHANNEL_PIN_OUT, CHANNEL_PIN_OE_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // a pin move needs a write or a rising flag two edges back; irq loads with status, one edge sooner
    wire logic acc = PSEL_IN && PENABLE_IN;
    property p_ans; PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
    a_err: assert property (p_err) else $error("lone error");
    property p_idle; !PREADY_OUT |-> PRDATA_OUT == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray data");
    property p_top; PRDATA_OUT[31:CH] == '0; endproperty
    a_top: assert property (p_top) else $error("upper bits set");
    property p_pin; $changed({CHANNEL_PIN_OUT, CHANNEL_PIN_OE_OUT}) |->
        $past(acc && PWRITE_IN, 2) || ($past(ALERT_FLAGS_IN, 2) & ~$past(ALERT_FLAGS_IN, 3)) != '0; endproperty
    a_pin: assert property (p_pin) else $error("pin moved alone");
    property p_irq_up; $rose(IRQ_OUT) |->
        $past(acc && PWRITE_IN, 2) || ($past(ALERT_FLAGS_IN, 1) & ~$past(ALERT_FLAGS_IN, 2)) != '0; endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose alone");
    property p_irq_dn; $fell(IRQ_OUT) |-> $past(acc, 1) || $past(acc, 2); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell alone");
endmodule
bind atou_top atou_top_chk #(.CH(CH), .AW(AW)) atou_top_chk_inst (.MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .PRDATA_OUT(PRDATA_OUT), .PSTRB_IN(PSTRB_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .IRQ_OUT(IRQ_OUT), .ALERT_FLAGS_IN(ALERT_FLAGS_IN), .CHANNEL_PIN_IN(CHANNEL_PIN_IN),
    .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT), .CHANNEL_PIN_OE_OUT(CHANNEL_PIN_OE_OUT));

// *** test/test_alert_triggered_output_update.sv ***
`timescale 1ns/1ps
`include "atou_cfg.svh"
module test_alert_triggered_output_update;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] alert, src, src_en, pin, pin_drv, pin_oe;
    int n_fail, checked;
    atou_top atou_top_inst (.MCLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ALERT_FLAGS_IN(alert), .CHANNEL_PIN_IN(pin),
        .CHANNEL_PIN_OUT(pin_drv), .CHANNEL_PIN_OE_OUT(pin_oe), .IRQ_OUT(irq));
    atou_pins_model atou_pins_model_inst (.drive_in(pin_drv), .oe_in(pin_oe), .src_in(src),
        .src_en_in(src_en), .pin_out(pin));
    // ----
    // helpers
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one edge idle before setup so a release never meets a new request
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs;
        apb(1'b0, `ATOU_OFF_SEL_BASE, 0);
        chk(rd, 32'h2);
        apb(1'b0, `ATOU_OFF_TRIG_LEVEL, 0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0fc, 0);
        chk({rd[30:0], err}, 32'h1);
    endtask
    // bits 0-3 push-pull, 4 input, 5-7 open-drain
    task automatic t_modes;
        apb(1'b1, `ATOU_OFF_PIN_DIGITAL, 32'hff);
        apb(1'b1, `ATOU_OFF_PIN_OUTPUT, 32'hef);
        apb(1'b1, `ATOU_OFF_PIN_PUSH_PULL, 32'h0f);
        apb(1'b1, `ATOU_OFF_OUTPUT_LEVEL, 32'h81);
        settle(1);
        chk({pin_oe, pin_drv, pin}, {8'h6f, 8'h01, 8'h91});
        apb(1'b0, `ATOU_OFF_INPUT_READBACK, 0);
        chk(rd, 32'h10);
        src <= 8'h00;
        settle(4);
        apb(1'b0, `ATOU_OFF_INPUT_READBACK, 0);
        chk(rd, 32'h0);
        apb(1'b1, `ATOU_OFF_OUTPUT_LEVEL, 32'h0);
    endtask
    // lanes 4 and 7 disabled, lane 3 listens to channel 3 only
    task automatic t_trig;
        apb(1'b1, `ATOU_OFF_TRIG_LEVEL, 32'had);
        apb(1'b1, `ATOU_OFF_TRIG_ENABLE, 32'h6f);
        apb(1'b1, `ATOU_OFF_SEL_BASE + 12'h00c, 32'h08);
        apb(1'b1, `ATOU_OFF_IRQ_MASK, 32'h08);
        alert <= 8'h02;
        settle(1);
        chk(pin_drv, 32'h0);
        settle(1);
        chk({pin_oe, pin_drv, irq}, {8'hcf, 8'h05, 1'b0});
        apb(1'b0, `ATOU_OFF_OUTPUT_LEVEL, 0);
        chk(rd, 32'h25);
        alert <= 8'h0a;
        settle(3);
        chk({pin_oe, pin_drv, irq}, {8'hcf, 8'h0d, 1'b1});
        apb(1'b0, `ATOU_OFF_IRQ_STATUS, 0);
        chk(rd, 32'h6f);
        settle(2);
        chk(irq, 32'h0);
        apb(1'b0, `ATOU_OFF_IRQ_STATUS, 0);
        chk(rd, 32'h0);
        alert <= 8'h00;
    endtask
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, alert} = '0;
        pstrb = 4'hf;
        src = 8'h10;
        src_en = 8'h10;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_modes;
        t_trig;
        summarize;
    end
    initial begin
        #50000;
        n_fail++;
        summarize;
    end
endmodule
